// [rtl/abu_pkg.sv]
// Package with constants and carrier types of the address breakpoint unit.
`default_nettype none
package abu_pkg;

   // Register byte addresses on the Wishbone bus.
   localparam logic [4:0] ABU_OFS_STATUS_CONTROL = 5'h00;
   localparam logic [4:0] ABU_OFS_ADDRESS_HIGH   = 5'h04;
   localparam logic [4:0] ABU_OFS_ADDRESS_LOW    = 5'h08;
   localparam logic [4:0] ABU_OFS_AUXILIARY      = 5'h0C;
   localparam logic [4:0] ABU_OFS_WAIT_STATUS    = 5'h10;
   localparam logic [4:0] ABU_OFS_FLAG_CONTROL   = 5'h14;
   localparam logic [4:0] ABU_OFS_IRQ_STATUS     = 5'h18;
   localparam logic [4:0] ABU_OFS_IRQ_MASK       = 5'h1C;

   // Field positions.
   localparam int ABU_BIT_BREAK_ENABLE   = 7;
   localparam int ABU_BIT_BREAK_ACTIVE   = 6;
   localparam int ABU_BIT_WDOG_HOLD      = 0;
   localparam int ABU_BIT_WAIT_EXIT      = 1;
   localparam int ABU_BIT_FLAG_CLEAR_EN  = 7;
   localparam int ABU_BIT_IRQ_ADDR_BREAK = 0;
   localparam int ABU_BIT_IRQ_SOFT_BREAK = 1;
   localparam int ABU_BIT_IRQ_WAIT_EXIT  = 2;

   // Values after reset.
   localparam logic [7:0] ABU_RST_BYTE = 8'h00;
   localparam logic [2:0] ABU_RST_IRQ  = 3'h0;

   // Break vectors.
   localparam logic [15:0] ABU_VECTOR_NORMAL  = 16'hFFFC;
   localparam logic [15:0] ABU_VECTOR_MONITOR = 16'hFEFC;

   // Handshake latency of the bus slave in cycles.
   localparam int ABU_WB_LATENCY = 1;

   // Signals from the CPU core.
   typedef struct packed {
      logic [15:0] addr;          // CPU generated address.
      logic        addr_valid;    // Address is a CPU fetch this cycle.
      logic        opcode_fetch;  // Address is an opcode, not an operand.
      logic        insn_end;      // Last cycle of the current instruction.
      logic        rti_done;      // Return-from-interrupt op executed.
      logic        wait_mode;     // CPU in wait mode.
      logic        stop_mode;     // CPU in stop mode.
      logic        wait_wake;     // Wait mode has been left; held until the break request.
      logic        monitor_mode;  // Monitor mode latched.
   } abu_cpu_s;

   // Controls toward the system integration unit and other modules.
   typedef struct packed {
      logic        breakpoint_request; // One-cycle break request.
      logic [15:0] vector_addr;        // Break vector address.
      logic [7:0]  software_interrupt_op; // Opcode forced into the IR.
      logic        break_state;        // Break routine in progress.
      logic        watchdog_hold;      // Watchdog timer suppressed.
      logic        flag_clear_allow;   // Status flags may be cleared.
      logic        timer_freeze;       // Timer counter halted.
      logic        capture_inhibit;    // Input captures blocked.
   } abu_ctl_s;

endpackage : abu_pkg
`default_nettype wire

// [rtl/abu_break_unit.sv]
// Address breakpoint unit with Wishbone register access.
`default_nettype none
module abu_break_unit
   import abu_pkg::*;
#(
   parameter int         ADDR_W  = 16,
   parameter logic [7:0] SWI_OP  = 8'h00
) (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // CPU core side.
   input  wire abu_cpu_s    cpu_i,
   // System integration side.
   output abu_ctl_s         ctl_o,
   // Interrupt.
   output logic             irq_o
);

   if (ADDR_W != 16) begin : g_chk
      $error("abu_break_unit serves only a 16-bit address");
   end

   logic       enable_r;
   logic       active_r;
   logic [7:0] addr_hi_r;
   logic [7:0] addr_lo_r;
   logic       wdog_hold_r;
   logic       wait_exit_r;
   logic       flag_clr_en_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic       armed_r;
   logic       operand_pend_r;
   logic       soft_pend_r;
   logic       break_state_r;
   logic       req_r;
   logic [15:0] vector_r;
   logic [31:0] rdata_r;
   logic       ack_r;

   // Bus decode.
   logic       access;
   logic       wr_lane0;
   logic       wr_scr;
   logic       wr_hi;
   logic       wr_lo;
   logic       wr_aux;
   logic       wr_wst;
   logic       wr_bfc;
   logic       wr_ist;
   logic       wr_imk;
   logic [7:0] wbyte;

   assign access   = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr_lane0 = access && wb_we_i && wb_sel_i[0];
   assign wbyte    = wb_dat_i[7:0];
   assign wr_scr   = wr_lane0 && (wb_adr_i == ABU_OFS_STATUS_CONTROL);
   assign wr_hi    = wr_lane0 && (wb_adr_i == ABU_OFS_ADDRESS_HIGH);
   assign wr_lo    = wr_lane0 && (wb_adr_i == ABU_OFS_ADDRESS_LOW);
   assign wr_aux   = wr_lane0 && (wb_adr_i == ABU_OFS_AUXILIARY);
   assign wr_wst   = wr_lane0 && (wb_adr_i == ABU_OFS_WAIT_STATUS);
   assign wr_bfc   = wr_lane0 && (wb_adr_i == ABU_OFS_FLAG_CONTROL);
   assign wr_ist   = wr_lane0 && (wb_adr_i == ABU_OFS_IRQ_STATUS);
   assign wr_imk   = wr_lane0 && (wb_adr_i == ABU_OFS_IRQ_MASK);

   // Address comparison and break sources.
   logic       cmp_hit;
   logic       hit;
   logic       opcode_hit;
   logic       operand_hit;
   logic       soft_set;
   logic       take_break;
   logic       soft_take;

   // Fetches in wait or stop never advance the address, so nothing fires.
   assign cmp_hit = cpu_i.addr_valid && !cpu_i.wait_mode &&
                    !cpu_i.stop_mode &&
                    (cpu_i.addr == {addr_hi_r, addr_lo_r});
   assign hit = enable_r && armed_r && cmp_hit &&
                !break_state_r;
   assign opcode_hit  = hit && cpu_i.opcode_fetch;
   assign operand_hit = hit && !cpu_i.opcode_fetch;
   assign soft_set    = wr_scr && wbyte[ABU_BIT_BREAK_ACTIVE];

   // Software breaks and operand hits wait for the instruction boundary.
   assign soft_take = soft_pend_r && cpu_i.insn_end;
   assign take_break = !break_state_r && !req_r &&
      (opcode_hit ||
       (operand_pend_r && cpu_i.insn_end) || soft_take);

   // Break enable control.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_r <= 1'b0;
      end else if (wr_scr) begin
         enable_r <= wbyte[ABU_BIT_BREAK_ENABLE];
      end
   end

   // Break active bit: the hardware set wins over a software clear.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_r <= 1'b0;
      end else if (hit || soft_set) begin
         active_r <= 1'b1;
      end else if (wr_scr) begin
         active_r <= 1'b0;
      end
   end

   // Break address halves.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_hi_r <= ABU_RST_BYTE;
         addr_lo_r <= ABU_RST_BYTE;
      end else begin
         if (wr_hi) begin
            addr_hi_r <= wbyte;
         end
         if (wr_lo) begin
            addr_lo_r <= wbyte;
         end
      end
   end

   // A match disarms the comparator until a new address is loaded.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         armed_r <= 1'b1;
      end else if (wr_hi || wr_lo) begin
         armed_r <= 1'b1;
      end else if (hit) begin
         armed_r <= 1'b0;
      end
   end

   // Pending operand hit and software break.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         operand_pend_r <= 1'b0;
         soft_pend_r    <= 1'b0;
      end else begin
         if (take_break) begin
            operand_pend_r <= 1'b0;
         end else if (operand_hit) begin
            operand_pend_r <= 1'b1;
         end
         if (take_break) begin
            soft_pend_r <= 1'b0;
         end else if (soft_set && !break_state_r) begin
            soft_pend_r <= 1'b1;
         end
      end
   end

   // Break request pulse, vector and break state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_r    <= 1'b0;
         vector_r <= ABU_VECTOR_NORMAL;
      end else begin
         req_r <= take_break;
         if (take_break) begin
            vector_r <= cpu_i.monitor_mode ? ABU_VECTOR_MONITOR
                                           : ABU_VECTOR_NORMAL;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         break_state_r <= 1'b0;
      end else if (req_r) begin
         break_state_r <= 1'b1;
      end else if (cpu_i.rti_done) begin
         break_state_r <= 1'b0;
      end
   end

   // Auxiliary and flag control bits.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdog_hold_r   <= 1'b0;
         flag_clr_en_r <= 1'b0;
      end else begin
         if (wr_aux) begin
            wdog_hold_r <= wbyte[ABU_BIT_WDOG_HOLD];
         end
         if (wr_bfc) begin
            flag_clr_en_r <= wbyte[ABU_BIT_FLAG_CLEAR_EN];
         end
      end
   end

   // Wait exit flag: set when a break wakes the CPU, cleared by writing 0.
   logic wait_exit_set;
   assign wait_exit_set = take_break && cpu_i.wait_wake;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wait_exit_r <= 1'b0;
      end else if (wait_exit_set) begin
         wait_exit_r <= 1'b1;
      end else if (wr_wst && !wbyte[ABU_BIT_WAIT_EXIT]) begin
         wait_exit_r <= 1'b0;
      end
   end

   // Interrupt status, write one to clear, set wins.
   logic [2:0] irq_set;
   always_comb begin
      irq_set = 3'h0;
      irq_set[ABU_BIT_IRQ_ADDR_BREAK] = hit;
      irq_set[ABU_BIT_IRQ_SOFT_BREAK] = soft_take && take_break;
      irq_set[ABU_BIT_IRQ_WAIT_EXIT]  = wait_exit_set;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_r <= ABU_RST_IRQ;
      end else begin
         irq_stat_r <= irq_set |
                       (irq_stat_r & ~(wr_ist ? wbyte[2:0] : 3'h0));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_r <= ABU_RST_IRQ;
      end else if (wr_imk) begin
         irq_mask_r <= wbyte[2:0];
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

   // Read data and acknowledge; unmapped addresses read zero.
   logic [7:0] rbyte;
   always_comb begin
      rbyte = 8'h00;
      unique case (wb_adr_i)
         ABU_OFS_STATUS_CONTROL: begin
            rbyte[ABU_BIT_BREAK_ENABLE] = enable_r;
            rbyte[ABU_BIT_BREAK_ACTIVE] = active_r;
         end
         ABU_OFS_ADDRESS_HIGH: rbyte = addr_hi_r;
         ABU_OFS_ADDRESS_LOW:  rbyte = addr_lo_r;
         ABU_OFS_AUXILIARY:    rbyte[ABU_BIT_WDOG_HOLD] = wdog_hold_r;
         ABU_OFS_WAIT_STATUS:  rbyte[ABU_BIT_WAIT_EXIT] = wait_exit_r;
         ABU_OFS_FLAG_CONTROL: rbyte[ABU_BIT_FLAG_CLEAR_EN] = flag_clr_en_r;
         ABU_OFS_IRQ_STATUS:   rbyte[2:0] = irq_stat_r;
         ABU_OFS_IRQ_MASK:     rbyte[2:0] = irq_mask_r;
         default:              rbyte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r <= access;
         if (access && !wb_we_i) begin
            rdata_r <= {24'h00_0000, rbyte};
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;

   // Outputs toward the system integration unit and peripherals.
   always_comb begin
      ctl_o.breakpoint_request    = req_r;
      ctl_o.vector_addr           = vector_r;
      ctl_o.software_interrupt_op = SWI_OP;
      ctl_o.break_state           = break_state_r;
      ctl_o.watchdog_hold         = break_state_r && wdog_hold_r &&
                                    cpu_i.monitor_mode;
      ctl_o.flag_clear_allow      = !break_state_r ||
                                    flag_clr_en_r;
      ctl_o.timer_freeze          = break_state_r;
      ctl_o.capture_inhibit       = break_state_r;
   end

endmodule : abu_break_unit
`default_nettype wire

// [verification/abu_cpu_model.sv]
// CPU core model that fetches four-byte instructions for the unit.
`default_nettype none
module abu_cpu_model
   import abu_pkg::*;
(
   // Clock and reset.
   input  wire logic     clk_i,
   input  wire logic     rst_i,
   // Bench controls.
   input  wire logic     run_i,
   input  wire logic     rti_i,
   input  wire logic     mon_i,
   input  wire logic     wait_i,
   // Unit side.
   input  wire abu_ctl_s ctl_i,
   output abu_cpu_s      cpu_o
);
   logic [15:0] pc_r;
   logic [15:0] ret_r;
   logic        go;
   logic        wait_q;
   logic        wake_r;

   assign go = run_i & ~wait_i;

   // Leaving wait stays flagged until the break that ends it is requested.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wait_q <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         wait_q <= wait_i;
         if (ctl_i.breakpoint_request) begin
            wake_r <= 1'b0;
         end else if (wait_q && !wait_i) begin
            wake_r <= 1'b1;
         end
      end
   end

   // A break jumps to the vector and remembers the next unexecuted opcode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_r  <= 16'h0000;
         ret_r <= 16'h0000;
      end else if (ctl_i.breakpoint_request) begin
         pc_r  <= ctl_i.vector_addr;
         ret_r <= {pc_r[15:2], 2'b00};
      end else if (rti_i) begin
         pc_r <= ret_r;
      end else if (go) begin
         pc_r <= pc_r + 16'h0001;
      end
   end

   always_comb begin
      cpu_o              = '0;
      cpu_o.addr         = pc_r;
      cpu_o.addr_valid   = go;
      cpu_o.opcode_fetch = go & (pc_r[1:0] == 2'h0);
      cpu_o.insn_end     = go & (pc_r[1:0] == 2'h3);
      cpu_o.rti_done     = rti_i;
      cpu_o.wait_mode    = wait_i;
      cpu_o.wait_wake    = wake_r;
      cpu_o.monitor_mode = mon_i;
   end
endmodule // abu_cpu_model
`default_nettype wire

// [verification/abu_break_unit_properties.sv]
// Port checks of the address breakpoint unit.
`default_nettype none
module abu_break_unit_props
   import abu_pkg::*;
(
   // Watched ports.
   input wire logic     clk_i,
   input wire logic     rst_i,
   input wire logic     wb_cyc_i,
   input wire logic     wb_stb_i,
   input wire logic     wb_ack_o,
   input wire abu_cpu_s cpu_i,
   input wire abu_ctl_s ctl_o,
   input wire logic     irq_o
);
   logic req;
   logic brk;
   assign req = ctl_o.breakpoint_request;
   assign brk = ctl_o.break_state;

   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_ack_pulse:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
   chk_ack_answer:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("late ack");
   chk_req_pulse:
      assert property (req |=> !req) else $error("long request");
   chk_break_follows:
      assert property (req |=> brk) else $error("no break state");
   chk_busy_quiet:
      assert property (brk |-> !req) else $error("request in break");
   chk_rti_end:
      assert property (brk && cpu_i.rti_done |=> !brk)
      else $error("break not ended");
   chk_timer_hold:
      assert property (ctl_o.timer_freeze == brk
         && ctl_o.capture_inhibit == brk) else $error("timer not held");
   chk_vector_pick:
      assert property (req |-> ctl_o.vector_addr == ($past(cpu_i.monitor_mode)
         ? ABU_VECTOR_MONITOR : ABU_VECTOR_NORMAL)) else $error("bad vector");
   chk_wdog_hold:
      assert property (ctl_o.watchdog_hold |-> brk && cpu_i.monitor_mode)
      else $error("watchdog held wrongly");
   chk_flag_free:
      assert property (!brk |-> ctl_o.flag_clear_allow)
      else $error("flags locked");
   chk_req_cause:
      assert property (req |-> $past(cpu_i.insn_end) || $past(cpu_i.opcode_fetch)
         && !$past(cpu_i.wait_mode) && !$past(cpu_i.stop_mode))
      else $error("request without cause");

   cov_monitor: cover property (req && cpu_i.monitor_mode);
   cov_rti: cover property (brk && cpu_i.rti_done);
   cov_irq: cover property (wb_ack_o && irq_o);
endmodule // abu_break_unit_props

bind abu_break_unit abu_break_unit_props u_abu_break_unit_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .cpu_i(cpu_i), .ctl_o(ctl_o), .irq_o(irq_o));
`default_nettype wire

// [verification/abu_break_unit_tb.sv]
// Self-checking bench of the address breakpoint unit.
`default_nettype none
module abu_break_unit_tb
   import abu_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [4:0]  wb_adr_i = 5'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        wb_ack_o, irq_o, hit;
   logic        run_r = 1'b0, rti_r = 1'b0, mon_r = 1'b0, wait_r = 1'b0;
   abu_cpu_s    cpu_i;
   abu_ctl_s    ctl_o;
   int          mismatches = 0, checks_done = 0;
   logic [7:0]  q;
   logic [15:0] a;

   always #2 clk_i = ~clk_i;

   abu_break_unit u_abu_break_unit (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_i(cpu_i),
      .ctl_o(ctl_o), .irq_o(irq_o));
   abu_cpu_model u_abu_cpu_model (.clk_i(clk_i), .rst_i(rst_i),
      .run_i(run_r), .rti_i(rti_r), .mon_i(mon_r), .wait_i(wait_r),
      .ctl_i(ctl_o), .cpu_o(cpu_i));

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // Classic cycle held until ack is sampled high at a rising edge.
   task automatic bus(input logic [4:0] ad, input logic we,
                      input logic [7:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= ad;
      wb_dat_i <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         mismatches++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [4:0] ad, input logic [7:0] d);
      bus(ad, 1'b1, d);
   endtask

   task automatic rd(input logic [4:0] ad, input logic [7:0] exp);
      bus(ad, 1'b0, 8'h00);
      check(q, exp);
   endtask

   task automatic req(input int n);
      hit = 1'b0;
      for (int i = 0; i < n && !hit; i++) begin
         @(posedge clk_i);
         hit = (ctl_o.breakpoint_request === 1'b1);
      end
   endtask

   task automatic leave;
      wr(ABU_OFS_STATUS_CONTROL, 8'h80);
      @(posedge clk_i);
      rti_r <= 1'b1;
      @(posedge clk_i);
      rti_r <= 1'b0;
      @(posedge clk_i);
      check(ctl_o.break_state, 1'b0);
   endtask

   task automatic t_reset;
      for (int i = 0; i < 8; i++)
         rd(5'(i * 4), 8'h00);
      rd(5'h13, 8'h00);
      check(irq_o, 1'b0);
   endtask

   task automatic t_opcode;
      wr(ABU_OFS_ADDRESS_HIGH, 8'h00);
      wr(ABU_OFS_ADDRESS_LOW, 8'h10);
      wr(ABU_OFS_STATUS_CONTROL, 8'h80);
      rd(ABU_OFS_STATUS_CONTROL, 8'h80);
      run_r <= 1'b1;
      req(60);
      check(hit, 1'b1);
      check(cpu_i.addr, 16'h0011);
      check(ctl_o.vector_addr, ABU_VECTOR_NORMAL);
      check(ctl_o.software_interrupt_op, 8'h00);
      @(posedge clk_i);
      check(ctl_o.timer_freeze & ctl_o.capture_inhibit, 1'b1);
      check(ctl_o.flag_clear_allow, 1'b0);
      rd(ABU_OFS_STATUS_CONTROL, 8'hC0);
      wr(ABU_OFS_FLAG_CONTROL, 8'h80);
      check(ctl_o.flag_clear_allow, 1'b1);
      leave();
      req(40);
      check(hit, 1'b0);
      wr(ABU_OFS_ADDRESS_HIGH, 8'h01);
      wr(ABU_OFS_ADDRESS_LOW, 8'h01);
      req(400);
      check(hit, 1'b1);
      check(cpu_i.addr, 16'h0104);
      leave();
   endtask

   task automatic t_soft;
      mon_r <= 1'b1;
      wr(ABU_OFS_AUXILIARY, 8'h01);
      wr(ABU_OFS_STATUS_CONTROL, 8'hC0);
      req(20);
      check(hit, 1'b1);
      check(cpu_i.addr[1:0], 2'h0);
      check(ctl_o.vector_addr, ABU_VECTOR_MONITOR);
      @(posedge clk_i);
      check(ctl_o.watchdog_hold, 1'b1);
      leave();
      mon_r <= 1'b0;
   endtask

   task automatic t_quiet;
      wr(ABU_OFS_STATUS_CONTROL, 8'h00);
      a = {cpu_i.addr[15:2] + 14'h10, 2'b00};
      wr(ABU_OFS_ADDRESS_HIGH, a[15:8]);
      wr(ABU_OFS_ADDRESS_LOW, a[7:0]);
      req(120);
      check(hit, 1'b0);
      wait_r <= 1'b1;
      @(posedge clk_i);
      a = {cpu_i.addr[15:2] + 14'h1, 2'b00};
      wr(ABU_OFS_ADDRESS_HIGH, a[15:8]);
      wr(ABU_OFS_ADDRESS_LOW, a[7:0]);
      wr(ABU_OFS_STATUS_CONTROL, 8'h80);
      req(40);
      check(hit, 1'b0);
      rd(ABU_OFS_STATUS_CONTROL, 8'h80);
      wait_r <= 1'b0;
      req(20);
      check(hit, 1'b1);
      leave();
   endtask

   task automatic t_irq;
      rd(ABU_OFS_IRQ_STATUS, 8'h07);
      rd(ABU_OFS_WAIT_STATUS, 8'h02);
      wr(ABU_OFS_WAIT_STATUS, 8'h00);
      rd(ABU_OFS_WAIT_STATUS, 8'h00);
      check(irq_o, 1'b0);
      wr(ABU_OFS_IRQ_MASK, 8'h02);
      check(irq_o, 1'b1);
      wr(ABU_OFS_IRQ_STATUS, 8'h07);
      rd(ABU_OFS_IRQ_STATUS, 8'h00);
      check(irq_o, 1'b0);
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_opcode();
      t_soft();
      t_quiet();
      t_irq();
      tally_and_finish();
   end
endmodule // abu_break_unit_tb
`default_nettype wire
